// File: pkg/sclm_pkg.sv
package sclm_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned AVG_WINDOW_S = 10;
   localparam int unsigned AVG_SAMPLES = AVG_WINDOW_S * 1000 / TICK_MS;
   localparam int unsigned DEC_TIME_MAX = 1200;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_DEC_TIME = 5'h04;
   localparam logic [4:0] OFS_PRESET = 5'h08;
   localparam logic [4:0] OFS_REF_LEVEL = 5'h0c;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   localparam logic [4:0] OFS_MASK = 5'h14;
   localparam logic [4:0] OFS_STATE = 5'h18;
   localparam logic [4:0] OFS_DECEL_STEP = 5'h1c;

   // ****************************************
   // Control and status fields
   // ****************************************
   localparam int unsigned CTRL_SRC_LSB = 0;
   localparam int unsigned CTRL_KPA_LSB = 2;
   localparam int unsigned CTRL_CLA_LSB = 4;
   localparam int unsigned CTRL_CRIT_BIT = 7;
   localparam int unsigned CTRL_JOG_BIT = 8;
   localparam int unsigned ST_KP_BIT = 0;
   localparam int unsigned ST_CMD_BIT = 1;

   typedef enum logic [1:0] {
      SCLM_SRC_KEYPAD = 2'h0,
      SCLM_SRC_ANALOG = 2'h1,
      SCLM_SRC_COMM = 2'h2
   } sclm_src_e;

   typedef enum logic [1:0] {
      SCLM_KP_NONE = 2'h0,
      SCLM_KP_WARN = 2'h1,
      SCLM_KP_FREERUN = 2'h2,
      SCLM_KP_DEC = 2'h3
   } sclm_kp_e;

   typedef enum logic [2:0] {
      SCLM_CL_NONE = 3'h0,
      SCLM_CL_FREERUN = 3'h1,
      SCLM_CL_DEC = 3'h2,
      SCLM_CL_HOLD_IN = 3'h3,
      SCLM_CL_HOLD_OUT = 3'h4,
      SCLM_CL_PRESET = 3'h5
   } sclm_cl_e;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] RST_SRC = 2'h0;
   localparam logic [1:0] RST_KPA = 2'h2;
   localparam logic [2:0] RST_CLA = 3'h1;
   localparam logic RST_CRIT = 1'b0;
   localparam logic RST_JOG = 1'b0;
   localparam logic [10:0] RST_DEC_TIME = 11'h00a;
   localparam logic [15:0] RST_PRESET = 16'h0000;
   localparam logic [15:0] RST_REF_LEVEL = 16'h0000;
   localparam logic [15:0] RST_DECEL_STEP = 16'h0064;
   localparam logic [1:0] RST_MASK = 2'h0;
endpackage

// File: design/sclm_top.sv
`timescale 1ns/1ps
module sclm_top #(
   parameter int unsigned TICK_CYCLES = sclm_pkg::TICK_CYCLES_DFLT,
   parameter int unsigned FREQ_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic keypad_link_ok,
   input wire logic [FREQ_W-1:0] keypad_freq,
   input wire logic jog_active,
   input wire logic [FREQ_W-1:0] analog_in,
   input wire logic comm_cmd_valid,
   input wire logic [FREQ_W-1:0] comm_freq,
   output logic [FREQ_W-1:0] oper_freq,
   output logic output_block,
   output logic decel_active,
   output logic warn_keypad_lost,
   output logic warn_cmd_lost,
   output logic irq
);
   import sclm_pkg::*;

   if (FREQ_W < 8 || FREQ_W > 16 || TICK_CYCLES < 2) begin : g_param_check
      $error("sclm_top: unsupported parameters");
   end

   localparam int TW = $clog2(TICK_CYCLES);
   localparam int SW = FREQ_W + $clog2(AVG_SAMPLES);
   localparam int AW = $clog2(AVG_SAMPLES);

   // ****************************************
   // Pin synchroniser and tick divider
   // ****************************************
   logic kp_s1_q, kp_s2_q;
   logic [TW-1:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = (tick_cnt_q == TW'(TICK_CYCLES - 1));
      tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         kp_s1_q <= 1'b1;
         kp_s2_q <= 1'b1;
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         kp_s1_q <= keypad_link_ok;
         kp_s2_q <= kp_s1_q;
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [1:0] src_q, src_d;
   logic [1:0] kpa_q, kpa_d;
   logic [2:0] cla_q, cla_d;
   logic crit_q, crit_d, jog_sel_q, jog_sel_d;
   logic [10:0] dec_time_q, dec_time_d;
   logic [FREQ_W-1:0] preset_q, preset_d, ref_q, ref_d, step_q, step_d;
   logic [1:0] status_q, status_d, mask_q, mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d, irq_q, irq_d;
   logic acc, wr, rd, kp_event, cmd_event;
   logic kp_lost_q, cmd_lost_q;
   logic [FREQ_W-1:0] freq_q;

   function automatic logic [31:0] zx(input logic [FREQ_W-1:0] v);
      zx = {{(32 - FREQ_W){1'b0}}, v};
   endfunction

   always_comb begin
      acc = (avs_read | avs_write) & ~wait_q;
      wr = acc & avs_write & avs_byteenable[0];
      // Read captured in the wait cycle so data stands when waitrequest drops
      rd = avs_read & wait_q;
      wait_d = ~((avs_read | avs_write) & wait_q);
      src_d = src_q;
      kpa_d = kpa_q;
      cla_d = cla_q;
      crit_d = crit_q;
      jog_sel_d = jog_sel_q;
      dec_time_d = dec_time_q;
      preset_d = preset_q;
      ref_d = ref_q;
      step_d = step_q;
      mask_d = mask_q;
      status_d = status_q;
      rdata_d = rdata_q;
      if (wr) begin
         case (avs_address)
            OFS_CTRL: begin
               src_d = avs_writedata[CTRL_SRC_LSB +: 2];
               kpa_d = avs_writedata[CTRL_KPA_LSB +: 2];
               cla_d = avs_writedata[CTRL_CLA_LSB +: 3];
               crit_d = avs_writedata[CTRL_CRIT_BIT];
               jog_sel_d = avs_writedata[CTRL_JOG_BIT];
            end
            OFS_DEC_TIME: begin
               dec_time_d = (avs_writedata[10:0] > 11'(DEC_TIME_MAX)) ? 11'(DEC_TIME_MAX) : avs_writedata[10:0];
            end
            OFS_PRESET: preset_d = avs_writedata[FREQ_W-1:0];
            OFS_REF_LEVEL: ref_d = avs_writedata[FREQ_W-1:0];
            OFS_MASK: mask_d = avs_writedata[1:0];
            OFS_DECEL_STEP: step_d = avs_writedata[FREQ_W-1:0];
            default: ;
         endcase
      end
      if (rd) begin
         case (avs_address)
            OFS_CTRL: rdata_d = {23'h000000, jog_sel_q, crit_q, cla_q, kpa_q, src_q};
            OFS_DEC_TIME: rdata_d = {21'h000000, dec_time_q};
            OFS_PRESET: rdata_d = zx(preset_q);
            OFS_REF_LEVEL: rdata_d = zx(ref_q);
            OFS_STATUS: rdata_d = {30'h00000000, status_q};
            OFS_MASK: rdata_d = {30'h00000000, mask_q};
            OFS_STATE: rdata_d = {14'h0000, cmd_lost_q, kp_lost_q, 16'h0000} | zx(freq_q);
            OFS_DECEL_STEP: rdata_d = zx(step_q);
            default: rdata_d = 32'h00000000;
         endcase
         if (avs_address == OFS_STATUS) begin
            status_d = 2'h0;
         end
      end
      // Hardware set wins over read clear
      if (kp_event) begin
         status_d[ST_KP_BIT] = 1'b1;
      end
      if (cmd_event) begin
         status_d[ST_CMD_BIT] = 1'b1;
      end
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         src_q <= RST_SRC;
         kpa_q <= RST_KPA;
         cla_q <= RST_CLA;
         crit_q <= RST_CRIT;
         jog_sel_q <= RST_JOG;
         dec_time_q <= RST_DEC_TIME;
         preset_q <= RST_PRESET[FREQ_W-1:0];
         ref_q <= RST_REF_LEVEL[FREQ_W-1:0];
         step_q <= RST_DECEL_STEP[FREQ_W-1:0];
         mask_q <= RST_MASK;
         status_q <= 2'h0;
         rdata_q <= 32'h00000000;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         src_q <= src_d;
         kpa_q <= kpa_d;
         cla_q <= cla_d;
         crit_q <= crit_d;
         jog_sel_q <= jog_sel_d;
         dec_time_q <= dec_time_d;
         preset_q <= preset_d;
         ref_q <= ref_d;
         step_q <= step_d;
         mask_q <= mask_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         irq_q <= irq_d;
      end
   end

   // ****************************************
   // Loss detection and decision timer
   // ****************************************
   logic kp_watch, kp_raw, cmd_raw, cmd_watch;
   logic [FREQ_W-1:0] cmd_freq, level;
   logic [10:0] dtmr_q, dtmr_d;
   logic kp_lost_d, cmd_lost_d;

   always_comb begin
      kp_watch = (src_q == SCLM_SRC_KEYPAD) | (jog_sel_q & jog_active);
      kp_raw = kp_watch & ~kp_s2_q;
      level = crit_q ? ref_q : (ref_q >> 1);
      cmd_watch = 1'b1;
      case (src_q)
         SCLM_SRC_ANALOG: begin
            cmd_freq = analog_in;
            cmd_raw = analog_in < level;
         end
         SCLM_SRC_COMM: begin
            cmd_freq = comm_freq;
            cmd_raw = ~comm_cmd_valid;
         end
         default: begin
            cmd_freq = keypad_freq;
            cmd_raw = 1'b0;
            cmd_watch = 1'b0;
         end
      endcase
      // Restart on any valid command
      if (!cmd_raw) begin
         dtmr_d = '0;
      end else if (tick_q && dtmr_q != 11'h7ff) begin
         dtmr_d = dtmr_q + 11'h001;
      end else begin
         dtmr_d = dtmr_q;
      end
      cmd_lost_d = cmd_watch & cmd_raw & (dtmr_q >= dec_time_q);
      kp_lost_d = kp_raw;
      kp_event = kp_lost_d & ~kp_lost_q;
      cmd_event = cmd_lost_d & ~cmd_lost_q;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dtmr_q <= '0;
         kp_lost_q <= 1'b0;
         cmd_lost_q <= 1'b0;
      end else begin
         dtmr_q <= dtmr_d;
         kp_lost_q <= kp_lost_d;
         cmd_lost_q <= cmd_lost_d;
      end
   end

   // ****************************************
   // 10 s running averages, frozen while lost
   // ****************************************
   logic [FREQ_W-1:0] avg [2];
   logic [FREQ_W-1:0] avg_src [2];
   assign avg_src[0] = cmd_freq;
   assign avg_src[1] = freq_q;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_avg
         logic [FREQ_W-1:0] mem [AVG_SAMPLES];
         logic [AW-1:0] ptr_q, ptr_d;
         logic [SW-1:0] sum_q, sum_d;
         logic smp;
         always_comb begin
            smp = tick_q & ~cmd_raw & ~cmd_lost_q;
            ptr_d = ptr_q;
            sum_d = sum_q;
            if (smp) begin
               sum_d = sum_q + SW'(avg_src[g]) - SW'(mem[ptr_q]);
               ptr_d = (ptr_q == AW'(AVG_SAMPLES - 1)) ? '0 : ptr_q + 1'b1;
            end
            avg[g] = FREQ_W'(sum_q / SW'(AVG_SAMPLES));
         end
         always_ff @(posedge clk) begin
            if (reset) begin
               ptr_q <= '0;
               sum_q <= '0;
            end else begin
               ptr_q <= ptr_d;
               sum_q <= sum_d;
            end
         end
         always_ff @(posedge clk) begin
            if (reset) begin
               for (int i = 0; i < AVG_SAMPLES; i++) begin
                  mem[i] <= '0;
               end
            end else if (smp) begin
               mem[ptr_q] <= avg_src[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // Protective action
   // ****************************************
   logic [FREQ_W-1:0] freq_d;
   logic blk_q, blk_d, dec_q, dec_d, wkp_q, wkp_d, wcl_q, wcl_d;

   always_comb begin
      freq_d = cmd_freq;
      blk_d = 1'b0;
      dec_d = 1'b0;
      wkp_d = kp_lost_q & (kpa_q == SCLM_KP_WARN);
      wcl_d = cmd_lost_q;
      if (kp_lost_q && kpa_q == SCLM_KP_FREERUN) begin
         blk_d = 1'b1;
      end else if (kp_lost_q && kpa_q == SCLM_KP_DEC) begin
         dec_d = 1'b1;
      end else if (cmd_lost_q) begin
         case (cla_q)
            SCLM_CL_FREERUN: blk_d = 1'b1;
            SCLM_CL_DEC: dec_d = 1'b1;
            SCLM_CL_HOLD_IN: freq_d = avg[0];
            SCLM_CL_HOLD_OUT: freq_d = avg[1];
            SCLM_CL_PRESET: freq_d = preset_q;
            default: freq_d = cmd_freq;
         endcase
      end
      if (blk_d) begin
         freq_d = '0;
      end else if (dec_d) begin
         freq_d = freq_q;
         if (tick_q) begin
            freq_d = (freq_q > step_q) ? freq_q - step_q : '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         freq_q <= '0;
         blk_q <= 1'b0;
         dec_q <= 1'b0;
         wkp_q <= 1'b0;
         wcl_q <= 1'b0;
      end else begin
         freq_q <= freq_d;
         blk_q <= blk_d;
         dec_q <= dec_d;
         wkp_q <= wkp_d;
         wcl_q <= wcl_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign oper_freq = freq_q;
   assign output_block = blk_q;
   assign decel_active = dec_q;
   assign warn_keypad_lost = wkp_q;
   assign warn_cmd_lost = wcl_q;
   assign irq = irq_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_kp_src_gate: assert property (src_q != SCLM_SRC_KEYPAD && !(jog_sel_q && jog_active) |=> !kp_lost_q)
      else $error("keypad loss outside keypad source");
   a_kp_none_pass: assert property (kp_lost_q && kpa_q == SCLM_KP_NONE && !cmd_lost_q
      |=> oper_freq == $past(cmd_freq) && !output_block)
      else $error("keypad none altered frequency");
   a_kp_warn_out: assert property (kp_lost_q && kpa_q == SCLM_KP_WARN |=> warn_keypad_lost)
      else $error("keypad warning missing");
   a_kp_free_block: assert property (kp_raw && kpa_q == SCLM_KP_FREERUN |-> ##2 output_block)
      else $error("keypad free-run did not block");
   a_jog_watch: assert property (jog_sel_q && jog_active && !kp_s2_q |=> kp_lost_q)
      else $error("jog keypad loss missed");
   a_cl_free_block: assert property (cmd_lost_q && !kp_lost_q && cla_q == SCLM_CL_FREERUN
      |=> output_block && oper_freq == '0)
      else $error("command free-run did not block");
   a_cl_dec_ramp: assert property (decel_active && tick_q && oper_freq != '0 && dec_d
      |=> oper_freq < $past(oper_freq))
      else $error("deceleration did not lower frequency");
   a_cl_preset: assert property (cmd_lost_q && !kp_lost_q && cla_q == SCLM_CL_PRESET |=> oper_freq == $past(preset_q))
      else $error("preset frequency not applied");
   a_an_level: assert property (src_q == SCLM_SRC_ANALOG && analog_in >= (crit_q ? ref_q : ref_q >> 1)
      |=> dtmr_q == '0 && !cmd_lost_q)
      else $error("analog level misjudged");
   a_decide_wait: assert property ($rose(cmd_lost_q) |-> $past(dtmr_q) >= $past(dec_time_q))
      else $error("loss acted before decision time");
   a_comm_restart: assert property (src_q == SCLM_SRC_COMM && comm_cmd_valid |=> dtmr_q == '0 && !cmd_lost_q)
      else $error("valid command did not restart timer");
   a_irq_level: assert property (irq == |(status_q & mask_q))
      else $error("interrupt disagrees with status");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   c_kp_loss: cover property (kp_lost_q && kpa_q == SCLM_KP_WARN ##1 warn_keypad_lost);
   c_hold_in: cover property (cmd_lost_q && cla_q == SCLM_CL_HOLD_IN && src_q == SCLM_SRC_ANALOG);
   c_dec_stop: cover property (decel_active && oper_freq == '0);
   c_comm_loss: cover property (cmd_lost_q && src_q == SCLM_SRC_COMM);
endmodule

// File: test/sclm_src_model.sv
`timescale 1ns/1ps
// ****************************************
// Command source model: keypad, analog, comm
// ****************************************
module sclm_src_model (
   input wire logic clk,
   input wire logic kp_connect,
   input wire logic comm_on,
   input wire logic jog_on,
   input wire logic [15:0] cmd_freq,
   input wire logic [15:0] analog_lvl,
   output logic keypad_link_ok,
   output logic [15:0] keypad_freq,
   output logic jog_active,
   output logic [15:0] analog_in,
   output logic comm_cmd_valid,
   output logic [15:0] comm_freq
);
   initial begin
      keypad_link_ok = 1'b1;
      keypad_freq = 16'h0000;
      jog_active = 1'b0;
      analog_in = 16'h0000;
      comm_cmd_valid = 1'b0;
      comm_freq = 16'h0000;
   end
   // Released lines toggle instead of holding the last value
   always @(posedge clk) begin
      keypad_link_ok <= kp_connect;
      keypad_freq <= kp_connect ? cmd_freq : ~keypad_freq;
      jog_active <= jog_on;
      analog_in <= analog_lvl;
      comm_cmd_valid <= comm_on;
      comm_freq <= comm_on ? cmd_freq : ~comm_freq;
   end
endmodule

// File: test/speed_command_loss_monitor_tb.sv
`timescale 1ns/1ps
module speed_command_loss_monitor_tb;
   import sclm_pkg::*;
   localparam int unsigned TICK = 20;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, d;
   logic avs_waitrequest, kp_ok, jog_act, comm_vld;
   logic [15:0] kp_freq, an_in, cm_freq, oper_freq;
   logic output_block, decel_active, warn_keypad_lost, warn_cmd_lost, irq;
   logic kp_connect = 1'b1;
   logic comm_on = 1'b1;
   logic jog_on = 1'b0;
   logic [15:0] cmd_freq = 16'h0500;
   logic [15:0] analog_lvl = 16'h0200;
   int error_cnt = 0;
   int comparisons = 0;

   sclm_top #(.TICK_CYCLES(TICK), .FREQ_W(16)) i_sclm_top (.clk(clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .keypad_link_ok(kp_ok), .keypad_freq(kp_freq),
      .jog_active(jog_act), .analog_in(an_in), .comm_cmd_valid(comm_vld), .comm_freq(cm_freq),
      .oper_freq(oper_freq), .output_block(output_block), .decel_active(decel_active),
      .warn_keypad_lost(warn_keypad_lost), .warn_cmd_lost(warn_cmd_lost), .irq(irq));

   sclm_src_model i_sclm_src_model (.clk(clk), .kp_connect(kp_connect), .comm_on(comm_on),
      .jog_on(jog_on), .cmd_freq(cmd_freq), .analog_lvl(analog_lvl), .keypad_link_ok(kp_ok),
      .keypad_freq(kp_freq), .jog_active(jog_act), .analog_in(an_in),
      .comm_cmd_valid(comm_vld), .comm_freq(cm_freq));

   initial begin
      forever #2 clk = ~clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Avalon request held until waitrequest sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] v, output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) begin
         error_cnt++;
         stop_test();
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] r;
      bus(1'b1, a, v, r);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h00000000, r);
   endtask

   task automatic set_ctrl(input logic [1:0] s, input logic [1:0] k, input logic [2:0] c, input logic cr,
                           input logic j);
      wr(OFS_CTRL, {23'h000000, j, cr, c, k, s});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_regs();
      rd(OFS_CTRL, d);
      chk(d, {23'h000000, RST_JOG, RST_CRIT, RST_CLA, RST_KPA, RST_SRC});
      rd(OFS_DEC_TIME, d);
      chk(d, {21'h000000, RST_DEC_TIME});
      rd(OFS_PRESET, d);
      chk(d, {16'h0000, RST_PRESET});
      rd(OFS_MASK, d);
      chk(d, 32'h00000000);
      rd(OFS_DECEL_STEP, d);
      chk(d, {16'h0000, RST_DECEL_STEP});
      wr(OFS_STATUS, 32'h00000003);
      rd(OFS_STATUS, d);
      chk(d, 32'h00000000);
      rd(5'h02, d);
      chk(d, 32'h00000000);
      wr(OFS_DEC_TIME, 32'h000007ff);
      rd(OFS_DEC_TIME, d);
      chk(d, 32'h000004b0);
      wr(OFS_PRESET, 32'h00001234);
      rd(OFS_PRESET, d);
      chk(d, 32'h00001234);
      $display("test_regs done");
   endtask

   task automatic test_keypad();
      for (int k = 0; k < 4; k++) begin
         set_ctrl(SCLM_SRC_KEYPAD, 2'(k), SCLM_CL_NONE, 1'b0, 1'b0);
         kp_connect <= 1'b0;
         cyc(8);
         chk(warn_keypad_lost, k == 1);
         chk(output_block, k == 2);
         chk(decel_active, k == 3);
         kp_connect <= 1'b1;
         cyc(8);
         chk(output_block | decel_active | warn_keypad_lost, 1'b0);
      end
      set_ctrl(SCLM_SRC_COMM, SCLM_KP_FREERUN, SCLM_CL_NONE, 1'b0, 1'b1);
      kp_connect <= 1'b0;
      cyc(8);
      chk(output_block, 1'b0);
      jog_on <= 1'b1;
      cyc(8);
      chk(output_block, 1'b1);
      jog_on <= 1'b0;
      kp_connect <= 1'b1;
      cyc(8);
      $display("test_keypad done");
   endtask

   task automatic test_comm();
      logic [2:0] cl [4] = '{SCLM_CL_NONE, SCLM_CL_FREERUN, SCLM_CL_DEC, SCLM_CL_PRESET};
      wr(OFS_DEC_TIME, 32'h00000000);
      foreach (cl[i]) begin
         set_ctrl(SCLM_SRC_COMM, SCLM_KP_NONE, cl[i], 1'b0, 1'b0);
         comm_on <= 1'b0;
         cyc(8);
         chk(warn_cmd_lost, 1'b1);
         chk(output_block, cl[i] == SCLM_CL_FREERUN);
         chk(decel_active, cl[i] == SCLM_CL_DEC);
         if (cl[i] == SCLM_CL_PRESET) chk(oper_freq, 16'h1234);
         if (cl[i] == SCLM_CL_FREERUN) chk(oper_freq, 16'h0000);
         if (cl[i] == SCLM_CL_DEC) begin
            d = {16'h0000, oper_freq};
            cyc(2 * TICK);
            chk(oper_freq < d[15:0], 1'b1);
         end
         rd(OFS_STATE, d);
         chk(d[17], 1'b1);
         comm_on <= 1'b1;
         cyc(8);
         chk(warn_cmd_lost, 1'b0);
      end
      $display("test_comm done");
   endtask

   task automatic test_hold();
      for (int m = 3; m < 5; m++) begin
         set_ctrl(SCLM_SRC_COMM, SCLM_KP_NONE, 3'(m), 1'b0, 1'b0);
         cyc(110 * TICK);
         comm_on <= 1'b0;
         cyc(8);
         chk(oper_freq, 16'h0500);
         comm_on <= 1'b1;
         cyc(8);
      end
      $display("test_hold done");
   endtask

   task automatic test_analog();
      logic [16:0] tv [4] = '{{1'b0, 16'h00c0}, {1'b0, 16'h007f}, {1'b1, 16'h00c0}, {1'b1, 16'h0100}};
      logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      wr(OFS_REF_LEVEL, 32'h00000100);
      foreach (tv[i]) begin
         set_ctrl(SCLM_SRC_ANALOG, SCLM_KP_NONE, SCLM_CL_FREERUN, tv[i][16], 1'b0);
         analog_lvl <= tv[i][15:0];
         cyc(8);
         chk(output_block, ex[i]);
         analog_lvl <= 16'h0200;
         cyc(8);
      end
      $display("test_analog done");
   endtask

   task automatic test_decision();
      int n;
      wr(OFS_DEC_TIME, 32'h00000002);
      set_ctrl(SCLM_SRC_COMM, SCLM_KP_NONE, SCLM_CL_FREERUN, 1'b0, 1'b0);
      comm_on <= 1'b0;
      cyc(10);
      comm_on <= 1'b1;
      cyc(30);
      chk(warn_cmd_lost | output_block, 1'b0);
      rd(OFS_STATUS, d);
      comm_on <= 1'b0;
      n = 0;
      while (warn_cmd_lost !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) begin
         error_cnt++;
         stop_test();
      end
      chk(n >= 20 && n <= 60, 1'b1);
      cyc(2);
      chk(output_block, 1'b1);
      chk(irq, 1'b0);
      wr(OFS_MASK, 32'h00000002);
      cyc(2);
      chk(irq, 1'b1);
      rd(OFS_STATUS, d);
      chk(d, 32'h00000002);
      cyc(3);
      chk(irq, 1'b0);
      wr(OFS_MASK, 32'h00000000);
      comm_on <= 1'b1;
      cyc(8);
      $display("test_decision done");
   endtask

   initial begin
      cyc(10);
      reset <= 1'b0;
      cyc(2);
      test_regs();
      test_keypad();
      test_comm();
      test_hold();
      test_analog();
      test_decision();
      stop_test();
   end
endmodule
